/* File: rtl/rssd_imem.sv */
// instruction memory: 24 bytes, registered read, single-cycle clear
`timescale 1ns/100ps
module rssd_imem (
	input wire logic   mclk,
	input wire logic   rst,
	rssd_imem_if.mem   port
);

	typedef struct packed {
		logic [rssd_pkg::IMEM_DEPTH-1:0][7:0] word;
		logic [7:0]                           rdata;
	} rssd_imem_st_t;

	rssd_imem_st_t s_q;
	rssd_imem_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (port.raddr < rssd_pkg::PC_FULL) begin
			s_d.rdata = s_q.word[port.raddr];
		end else begin
			s_d.rdata = 8'h00;
		end
		// clear wins over a write in the same cycle
		if (port.clr) begin
			s_d.word = '0;
		end else if (port.we && port.waddr < rssd_pkg::PC_FULL) begin
			s_d.word[port.waddr] = port.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign port.rdata = s_q.rdata;

endmodule

/* File: rtl/rssd_imem_if.sv */
// instruction memory connection between sequencer core and its store
`timescale 1ns/100ps
interface rssd_imem_if;
	logic       we;
	logic [4:0] waddr;
	logic [7:0] wdata;
	logic       clr;
	logic [4:0] raddr;
	logic [7:0] rdata;

	modport ctrl (output we, output waddr, output wdata, output clr, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input clr, input raddr, output rdata);
endinterface

/* File: rtl/rssd_pkg.sv */
// shared constants and types for the radio strobe sequencer decode block
package rssd_pkg;

	// instruction memory geometry
	localparam int unsigned IMEM_DEPTH = 24;
	localparam int unsigned PC_W       = 5;
	localparam logic [4:0]  PC_LAST    = 5'h17;
	localparam logic [4:0]  PC_FULL    = 5'h18;
	localparam logic [4:0]  PC_RESET   = 5'h00;

	// program opcodes
	localparam logic [7:0] OP_HALT      = 8'hdf;
	localparam logic [7:0] OP_IDLE      = 8'hc0;
	localparam logic [3:0] OP_PROG_HI   = 4'hc;
	// immediate opcodes, taken from the host write port only
	localparam logic [7:0] OP_IMM_HALT  = 8'hff;
	localparam logic [7:0] OP_IMM_RUN   = 8'hfe;
	localparam logic [3:0] OP_IMM_HI    = 4'he;
	localparam logic [3:0] OP_STRB_MIN  = 4'h1;
	localparam logic [3:0] OP_STRB_MAX  = 4'h9;

	// one-hot strobe lanes toward the radio control state machine
	localparam int unsigned NUM_STROBES = 9;
	localparam int unsigned STB_TX_CAL  = 0;
	localparam int unsigned STB_RX_ON   = 1;
	localparam int unsigned STB_TX_ON   = 2;
	localparam int unsigned STB_TX_CCA  = 3;
	localparam int unsigned STB_RF_OFF  = 4;
	localparam int unsigned STB_RX_FLSH = 5;
	localparam int unsigned STB_TX_FLSH = 6;
	localparam int unsigned STB_ACK     = 7;
	localparam int unsigned STB_ACK_PND = 8;

	// branch condition codes and instruction fields
	localparam logic [2:0] CC_CCA   = 3'h0;
	localparam logic [2:0] CC_SFD   = 3'h1;
	localparam logic [2:0] CC_HOST  = 3'h2;
	localparam logic [2:0] CC_END   = 3'h3;
	localparam logic [2:0] CC_X0    = 3'h4;
	localparam logic [2:0] CC_Y0    = 3'h5;
	localparam logic [2:0] CC_Z0    = 3'h6;
	localparam int unsigned NEG_BIT = 3;

	// register map of the plain register port
	localparam logic [3:0] REG_INSTR  = 4'h0;
	localparam logic [3:0] REG_X      = 4'h1;
	localparam logic [3:0] REG_Y      = 4'h2;
	localparam logic [3:0] REG_Z      = 4'h3;
	localparam logic [3:0] REG_CTRL   = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_PC     = 4'h6;
	localparam logic [3:0] REG_WPTR   = 4'h7;
	localparam int unsigned CTRL_HOST_FLAG = 0;
	localparam int unsigned ST_RUNNING     = 0;
	localparam int unsigned ST_STROBE_BUSY = 1;
	localparam int unsigned ST_IMM_PEND    = 2;
	localparam int unsigned ST_MEM_FULL    = 3;

	typedef enum logic [1:0] {
		RSSD_HALT,
		RSSD_FETCH,
		RSSD_DECODE,
		RSSD_WAIT
	} rssd_state_t;

endpackage

/* File: rtl/rssd_top.sv */
// strobe processor decode: stop, start, idle and radio strobe instructions, branch conditions
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps

// Summary of operation
// - halt opcode stops, zeroes pc and write pointer, clears memory, label, flags halt
// - idle opcode only advances the program counter by one
// - tx synth calibration opcode strobes radio, stalls until acknowledged; test use
// - rx enable opcode pulses rx enable strobe, holds pc until acknowledged
// - tx enable opcode commands transmit, no advance until acknowledged
// - tx-if-clear transmits only on clear channel; software sets turnaround-off bit
// - radio off opcode disables rx, tx, synthesizer; stalls until acknowledged
// - rx flush opcode empties receive queue, resets demodulator, waits acknowledge
// - tx flush opcode empties transmit queue, waits acknowledge
// - ack frame opcode sends ack with pending cleared, waits acknowledge
// - ack pending opcode sends ack with pending set, waits acknowledge
// - immediate halt stops program, clears memory and label, flags halt
// - immediate run sets pc to zero and starts from first stored instruction
// - immediate tx synth calibration opcode strobes radio for tx calibration, stalls until acknowledged
// - immediate tx opcodes transmit, unconditionally or on clear channel, await ack
// - immediate radio off pulses radio off strobe and awaits acknowledge
// - immediate rx flush empties receive queue; software issues it twice
// - immediate tx flush empties transmit queue, awaits acknowledge
// - immediate ack opcodes send ack frame, pending cleared or set, await ack
// - condition 000 clear channel, 001 frame delimiter, 010 host flag
// - condition 011 true when program counter equals 23
// - conditions 100, 101, 110 test X, Y, Z for zero; 111 unused
// - selected condition is inverted by the instruction's negate bit
module rssd_top (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       radio_ack,
	input  wire logic       cca,
	input  wire logic       sfd,
	output logic            tx_synth_cal_strobe_out,
	output logic            rx_enable_strobe_out,
	output logic            tx_enable_strobe_out,
	output logic            tx_if_clear_strobe_out,
	output logic            radio_off_strobe_out,
	output logic            rx_flush_strobe_out,
	output logic            tx_flush_strobe_out,
	output logic            ack_frame_strobe_out,
	output logic            ack_pending_frame_strobe_out,
	output logic            program_halted_flag,
	output logic            label_invalidate,
	output logic            cond_met
);

	typedef struct packed {
		rssd_pkg::rssd_state_t                  state;
		logic [4:0]                             pc;
		logic [4:0]                             wptr;
		logic [rssd_pkg::NUM_STROBES-1:0]       strobe;
		logic                                   imm_pend;
		logic [rssd_pkg::NUM_STROBES-1:0]       imm_strobe;
		logic [7:0]                             x;
		logic [7:0]                             y;
		logic [7:0]                             z;
		logic                                   host_flag;
		logic [7:0]                             rdata;
		logic                                   halted;
		logic                                   label_clr;
		logic                                   cond;
	} rssd_st_t;

	rssd_st_t s_q;
	rssd_st_t s_d;

	rssd_imem_if imem ();

	rssd_imem u_imem (
		.mclk (mclk),
		.rst  (rst),
		.port (imem.mem)
	);

	// one-hot strobe lane for a C1..C9 or E1..E9 opcode, zero for anything else
	function automatic logic [rssd_pkg::NUM_STROBES-1:0] strobe_of(
		input logic [7:0] op,
		input logic [3:0] hi
	);
		logic [rssd_pkg::NUM_STROBES-1:0] r;
		logic [3:0]                       lane;
		r    = '0;
		lane = op[3:0] - rssd_pkg::OP_STRB_MIN;
		if (op[7:4] == hi && op[3:0] >= rssd_pkg::OP_STRB_MIN
				&& op[3:0] <= rssd_pkg::OP_STRB_MAX) begin
			r[lane] = 1'b1;
		end
		return r;
	endfunction

	// the conditional transmit lane is dropped while the channel is busy
	function automatic logic [rssd_pkg::NUM_STROBES-1:0] gate_cca(
		input logic [rssd_pkg::NUM_STROBES-1:0] stb,
		input logic                             clear
	);
		logic [rssd_pkg::NUM_STROBES-1:0] r;
		r = stb;
		if (!clear) begin
			r[rssd_pkg::STB_TX_CCA] = 1'b0;
		end
		return r;
	endfunction

	logic [rssd_pkg::NUM_STROBES-1:0] prog_stb;
	logic [rssd_pkg::NUM_STROBES-1:0] host_stb;
	logic                             host_wr;
	logic                             imm_go;
	logic                             cond_sel;
	logic [7:0]                       instr;
	logic [7:0]                       status;

	assign instr    = imem.rdata;
	assign host_wr  = reg_wr && reg_addr == rssd_pkg::REG_INSTR;
	assign prog_stb = strobe_of(instr, rssd_pkg::OP_PROG_HI);
	assign host_stb = strobe_of(reg_wdata, rssd_pkg::OP_IMM_HI);
	// immediate strobes own the radio handshake ahead of the program
	assign imm_go   = s_q.imm_pend && s_q.strobe == '0;

	assign status = {4'h0,
		s_q.wptr == rssd_pkg::PC_FULL,
		s_q.imm_pend,
		s_q.strobe != '0,
		s_q.state != rssd_pkg::RSSD_HALT};

	always_comb begin
		cond_sel = 1'b0;
		unique case (instr[2:0])
			rssd_pkg::CC_CCA:  cond_sel = cca;
			rssd_pkg::CC_SFD:  cond_sel = sfd;
			rssd_pkg::CC_HOST: cond_sel = s_q.host_flag;
			rssd_pkg::CC_END:  cond_sel = s_q.pc == rssd_pkg::PC_LAST;
			rssd_pkg::CC_X0:   cond_sel = s_q.x == 8'h00;
			rssd_pkg::CC_Y0:   cond_sel = s_q.y == 8'h00;
			rssd_pkg::CC_Z0:   cond_sel = s_q.z == 8'h00;
			default:           cond_sel = 1'b0;
		endcase
	end

	always_comb begin
		s_d           = s_q;
		s_d.halted    = 1'b0;
		s_d.label_clr = 1'b0;
		s_d.rdata     = 8'h00;
		imem.we       = 1'b0;
		imem.waddr    = s_q.wptr;
		imem.wdata    = reg_wdata;
		imem.clr      = 1'b0;
		imem.raddr    = s_q.pc;

		if (s_q.state == rssd_pkg::RSSD_DECODE) begin
			s_d.cond = cond_sel ^ instr[rssd_pkg::NEG_BIT];
		end

		if (s_q.strobe != '0 && radio_ack) begin
			s_d.strobe = '0;
		end
		if (imm_go) begin
			s_d.strobe   = s_q.imm_strobe;
			s_d.imm_pend = 1'b0;
		end

		unique case (s_q.state)
			rssd_pkg::RSSD_HALT: begin
			end
			rssd_pkg::RSSD_FETCH: begin
				// stall while the host has not yet written the next instruction
				if (s_q.pc < s_q.wptr) begin
					s_d.state = rssd_pkg::RSSD_DECODE;
				end
			end
			rssd_pkg::RSSD_DECODE: begin
				if (instr == rssd_pkg::OP_HALT) begin
					s_d.state     = rssd_pkg::RSSD_HALT;
					s_d.pc        = rssd_pkg::PC_RESET;
					s_d.wptr      = rssd_pkg::PC_RESET;
					imem.clr      = 1'b1;
					s_d.label_clr = 1'b1;
					s_d.halted    = 1'b1;
				end else if (instr == rssd_pkg::OP_IDLE) begin
					s_d.pc    = s_q.pc + 5'h01;
					s_d.state = rssd_pkg::RSSD_FETCH;
				end else if (prog_stb != '0) begin
					if (gate_cca(prog_stb, cca) == '0) begin
						s_d.pc    = s_q.pc + 5'h01;
						s_d.state = rssd_pkg::RSSD_FETCH;
					end else if (s_q.strobe == '0 && !s_q.imm_pend) begin
						s_d.strobe = prog_stb;
						s_d.state  = rssd_pkg::RSSD_WAIT;
					end
				end else begin
					// other opcodes belong to the register and branch logic
					s_d.pc    = s_q.pc + 5'h01;
					s_d.state = rssd_pkg::RSSD_FETCH;
				end
			end
			rssd_pkg::RSSD_WAIT: begin
				if (s_q.strobe != '0 && radio_ack) begin
					s_d.pc    = s_q.pc + 5'h01;
					s_d.state = rssd_pkg::RSSD_FETCH;
				end
			end
		endcase

		if (reg_wr) begin
			unique case (reg_addr)
				rssd_pkg::REG_X:    s_d.x = reg_wdata;
				rssd_pkg::REG_Y:    s_d.y = reg_wdata;
				rssd_pkg::REG_Z:    s_d.z = reg_wdata;
				rssd_pkg::REG_CTRL: s_d.host_flag = reg_wdata[rssd_pkg::CTRL_HOST_FLAG];
				default: begin
				end
			endcase
		end

		// immediates are never stored; halt and run act on arrival, strobes queue until no strobe is active
		if (host_wr) begin
			if (reg_wdata == rssd_pkg::OP_IMM_HALT) begin
				s_d.state     = rssd_pkg::RSSD_HALT;
				s_d.pc        = rssd_pkg::PC_RESET;
				s_d.wptr      = rssd_pkg::PC_RESET;
				imem.clr      = 1'b1;
				s_d.label_clr = 1'b1;
				s_d.halted    = 1'b1;
			end else if (reg_wdata == rssd_pkg::OP_IMM_RUN) begin
				s_d.pc    = rssd_pkg::PC_RESET;
				s_d.state = rssd_pkg::RSSD_FETCH;
			end else if (host_stb != '0) begin
				// queue immediate
				// a second immediate while one is pending is dropped
				if (!s_q.imm_pend && gate_cca(host_stb, cca) != '0) begin
					s_d.imm_pend   = 1'b1;
					s_d.imm_strobe = host_stb;
				end
			end else if (s_q.wptr < rssd_pkg::PC_FULL && s_d.state != rssd_pkg::RSSD_HALT
					|| s_q.wptr < rssd_pkg::PC_FULL && !s_d.halted) begin
				imem.we  = 1'b1;
				s_d.wptr = s_q.wptr + 5'h01;
			end
		end

		if (reg_rd) begin
			unique case (reg_addr)
				rssd_pkg::REG_X:      s_d.rdata = s_q.x;
				rssd_pkg::REG_Y:      s_d.rdata = s_q.y;
				rssd_pkg::REG_Z:      s_d.rdata = s_q.z;
				rssd_pkg::REG_CTRL:   s_d.rdata = {7'h00, s_q.host_flag};
				rssd_pkg::REG_STATUS: s_d.rdata = status;
				rssd_pkg::REG_PC:     s_d.rdata = {3'h0, s_q.pc};
				rssd_pkg::REG_WPTR:   s_d.rdata = {3'h0, s_q.wptr};
				default:              s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q       <= '0;
			s_q.state <= rssd_pkg::RSSD_HALT;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata                    = s_q.rdata;
	assign tx_synth_cal_strobe_out      = s_q.strobe[rssd_pkg::STB_TX_CAL];
	assign rx_enable_strobe_out         = s_q.strobe[rssd_pkg::STB_RX_ON];
	assign tx_enable_strobe_out         = s_q.strobe[rssd_pkg::STB_TX_ON];
	assign tx_if_clear_strobe_out       = s_q.strobe[rssd_pkg::STB_TX_CCA];
	assign radio_off_strobe_out         = s_q.strobe[rssd_pkg::STB_RF_OFF];
	assign rx_flush_strobe_out          = s_q.strobe[rssd_pkg::STB_RX_FLSH];
	assign tx_flush_strobe_out          = s_q.strobe[rssd_pkg::STB_TX_FLSH];
	assign ack_frame_strobe_out         = s_q.strobe[rssd_pkg::STB_ACK];
	assign ack_pending_frame_strobe_out = s_q.strobe[rssd_pkg::STB_ACK_PND];
	assign program_halted_flag          = s_q.halted;
	assign label_invalidate             = s_q.label_clr;
	assign cond_met                     = s_q.cond;

endmodule

/* File: verif/rssd_asserts.sv */
// port-level assertions for the strobe sequencer decode top
`timescale 1ns/100ps
module rssd_asserts (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       radio_ack,
	input wire logic       cca,
	input wire logic       sfd,
	input wire logic       tx_synth_cal_strobe_out,
	input wire logic       rx_enable_strobe_out,
	input wire logic       tx_enable_strobe_out,
	input wire logic       tx_if_clear_strobe_out,
	input wire logic       radio_off_strobe_out,
	input wire logic       rx_flush_strobe_out,
	input wire logic       tx_flush_strobe_out,
	input wire logic       ack_frame_strobe_out,
	input wire logic       ack_pending_frame_strobe_out,
	input wire logic       program_halted_flag,
	input wire logic       label_invalidate,
	input wire logic       cond_met
);
	logic [8:0] stb;
	logic [3:0] nib;
	logic       imm_w;
	assign stb = {ack_pending_frame_strobe_out, ack_frame_strobe_out, tx_flush_strobe_out,
		rx_flush_strobe_out, radio_off_strobe_out, tx_if_clear_strobe_out,
		tx_enable_strobe_out, rx_enable_strobe_out, tx_synth_cal_strobe_out};
	assign nib = reg_wdata[3:0];
	assign imm_w = reg_wr && reg_addr == rssd_pkg::REG_INSTR && reg_wdata[7:4] == 4'he;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	// quiet engine only, otherwise the strobe queues behind a busy one
	a_imm_lane: assert property (
		(imm_w && nib inside {[4'h1:4'h9]} && !$past(reg_wr) && stb == 9'h0 && (nib != 4'h4 || cca))
		##1 (stb == 9'h0 && ($past(nib) != 4'h4 || cca))
		|=> stb == (9'h1 << ($past(nib, 2) - 4'h1)))
		else $error("immediate strobe on wrong lane or late");
	a_cca_drop: assert property (
		(imm_w && nib == 4'h4 && !cca && stb == 9'h0 && !$past(reg_wr)) ##1 !cca
		|=> !tx_if_clear_strobe_out [*2])
		else $error("conditional transmit sent on busy channel");
	a_strobe_hold: assert property ((|stb && !radio_ack) |=> $stable(stb))
		else $error("strobe changed before acknowledge");
	a_strobe_drop: assert property ((|stb && radio_ack) |=> stb == 9'h0)
		else $error("strobe not released after acknowledge");
	a_strobe_onehot: assert property ($onehot0(stb))
		else $error("more than one strobe at once");
	a_halt_label: assert property (program_halted_flag == label_invalidate)
		else $error("halt and label pulses differ");
	a_halt_pulse: assert property (program_halted_flag |=> !program_halted_flag)
		else $error("halt flag longer than one cycle");
	a_halt_imm: assert property (
		(reg_wr && reg_addr == rssd_pkg::REG_INSTR && reg_wdata == 8'hff)
		|=> program_halted_flag)
		else $error("immediate halt raised no flag");
	c_ack: cover property (|stb && radio_ack);
	c_halt: cover property (program_halted_flag);
	c_cond: cover property (cond_met);
endmodule

/* File: verif/rssd_radio.sv */
// radio control state machine model, acks each strobe after a delay
`timescale 1ns/100ps
module rssd_radio (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [8:0] stb,
	input  wire logic [3:0] ack_delay,
	output logic            radio_ack
);
	logic [3:0] cnt_q;
	always_ff @(posedge mclk) begin
		if (rst || stb == 9'h0) begin
			cnt_q     <= 4'h0;
			radio_ack <= 1'b0;
		end else begin
			cnt_q     <= cnt_q + 4'h1;
			radio_ack <= cnt_q == ack_delay;
		end
	end
endmodule

/* File: verif/rssd_top_tb.sv */
// self-checking bench for the strobe sequencer decode top
`timescale 1ns/100ps
module rssd_top_tb;
	logic       mclk;
	logic       rst;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       radio_ack;
	logic       cca;
	logic       sfd;
	logic [8:0] stb;
	logic       program_halted_flag;
	logic       label_invalidate;
	logic       cond_met;
	logic [3:0] ack_delay;
	int         n_errors;
	int         check_count;

	rssd_top dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .radio_ack(radio_ack),
		.cca(cca), .sfd(sfd), .tx_synth_cal_strobe_out(stb[0]),
		.rx_enable_strobe_out(stb[1]), .tx_enable_strobe_out(stb[2]),
		.tx_if_clear_strobe_out(stb[3]), .radio_off_strobe_out(stb[4]),
		.rx_flush_strobe_out(stb[5]), .tx_flush_strobe_out(stb[6]),
		.ack_frame_strobe_out(stb[7]), .ack_pending_frame_strobe_out(stb[8]),
		.program_halted_flag(program_halted_flag), .label_invalidate(label_invalidate),
		.cond_met(cond_met));
	rssd_radio u_radio (.mclk(mclk), .rst(rst), .stb(stb), .ack_delay(ack_delay),
		.radio_ack(radio_ack));

	task automatic print_verdict();
		if (n_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk({1'b0, reg_rdata}, {1'b0, e});
	endtask

	// sel 0: any strobe, 1: no strobe, 2: halt pulse
	task automatic wait_sig(input int sel);
		int i;
		for (i = 0; i < 300; i++) begin
			if (sel == 0 && |stb === 1'b1) break;
			if (sel == 1 && stb === 9'h0) break;
			if (sel == 2 && program_halted_flag === 1'b1) break;
			@(posedge mclk);
			#1;
		end
		if (i == 300) begin
			n_errors++;
			$display("MISMATCH t=%0t wait timed out", $time);
			print_verdict();
		end
	endtask

	task automatic t_imm();
		int i;
		@(posedge mclk);
		cca <= 1'b1;
		for (i = 1; i <= 10; i++) begin
			@(posedge mclk);
			ack_delay <= i[0] ? 4'h5 : 4'h0;
			// tenth pass repeats the receive flush
			wr(rssd_pkg::REG_INSTR, {4'he, i == 10 ? 4'h6 : i[3:0]});
			wait_sig(0);
			chk(stb, 9'h1 << (i == 10 ? 5 : i - 1));
			wait_sig(1);
			chk(stb, 9'h0);
		end
		rd_chk(rssd_pkg::REG_WPTR, 8'h00);
		@(posedge mclk);
		cca <= 1'b0;
		wr(rssd_pkg::REG_INSTR, 8'he4);
		repeat (6) @(posedge mclk);
		#1;
		chk(stb, 9'h0);
	endtask

	task automatic t_prog();
		int i;
		@(posedge mclk);
		cca       <= 1'b1;
		ack_delay <= 4'h3;
		for (i = 0; i <= 9; i++) begin
			wr(rssd_pkg::REG_INSTR, 8'hc0 + i[7:0]);
		end
		wr(rssd_pkg::REG_INSTR, 8'hdf);
		wr(rssd_pkg::REG_INSTR, 8'hfe);
		for (i = 0; i < 9; i++) begin
			wait_sig(0);
			chk(stb, 9'h1 << i);
			wait_sig(1);
			chk(stb, 9'h0);
		end
		wait_sig(2);
		rd_chk(rssd_pkg::REG_PC, 8'h00);
		rd_chk(rssd_pkg::REG_WPTR, 8'h00);
		rd_chk(4'hf, 8'h00);
	endtask

	// program conditional transmit on a busy channel must skip without a strobe
	task automatic t_busy();
		int i;
		@(posedge mclk);
		cca <= 1'b0;
		wr(rssd_pkg::REG_INSTR, 8'hff);
		wr(rssd_pkg::REG_INSTR, 8'hc4);
		wr(rssd_pkg::REG_INSTR, 8'hc0);
		wr(rssd_pkg::REG_INSTR, 8'hfe);
		for (i = 0; i < 10; i++) begin
			@(posedge mclk);
			#1;
			chk(stb, 9'h0);
		end
		rd_chk(rssd_pkg::REG_PC, 8'h02);
	endtask

	task automatic t_cond();
		int c;
		int n;
		logic [7:0] tbl;
		for (n = 0; n < 2; n++) begin
			tbl = n ? 8'h9b : 8'h13;
			wr(rssd_pkg::REG_X, n ? 8'h03 : 8'h00);
			wr(rssd_pkg::REG_Y, n ? 8'h00 : 8'h05);
			wr(rssd_pkg::REG_Z, n ? 8'h00 : 8'h07);
			wr(rssd_pkg::REG_CTRL, n ? 8'h01 : 8'h00);
			@(posedge mclk);
			cca <= n == 0;
			sfd <= n == 0;
			for (c = 0; c < 8; c++) begin
				wr(rssd_pkg::REG_INSTR, 8'hff);
				wr(rssd_pkg::REG_INSTR, {4'h1, n[0], c[2:0]});
				wr(rssd_pkg::REG_INSTR, 8'hfe);
				repeat (6) @(posedge mclk);
				#1;
				chk({8'h0, cond_met}, {8'h0, tbl[c]});
			end
		end
		wr(rssd_pkg::REG_INSTR, 8'hff);
		for (c = 0; c < 23; c++) begin
			wr(rssd_pkg::REG_INSTR, 8'hc0);
		end
		wr(rssd_pkg::REG_INSTR, 8'h13);
		// full memory must refuse this one
		wr(rssd_pkg::REG_INSTR, 8'hc1);
		rd_chk(rssd_pkg::REG_WPTR, 8'h18);
		wr(rssd_pkg::REG_INSTR, 8'hfe);
		repeat (100) @(posedge mclk);
		#1;
		chk({8'h0, cond_met}, 9'h001);
		rd_chk(rssd_pkg::REG_PC, 8'h18);
	endtask

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial begin
		rst         = 1'b1;
		reg_addr    = 4'h0;
		reg_wdata   = 8'h00;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		cca         = 1'b0;
		sfd         = 1'b0;
		ack_delay   = 4'h0;
		n_errors    = 0;
		check_count = 0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_imm();
		t_prog();
		t_cond();
		t_busy();
		print_verdict();
	end
endmodule

bind rssd_top rssd_asserts u_chk (.*);
